/* File: inc/vlan_table_pkg.sv */
package vlan_table_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_AGING_CTRL  = 16'h1809;
    localparam logic [15:0] IDX_COMMAND     = 16'h180B;
    localparam logic [15:0] IDX_WRITE_DATA  = 16'h180C;
    localparam logic [15:0] IDX_READ_DATA   = 16'h180E;
    localparam logic [15:0] IDX_STATUS      = 16'h1810;
    localparam int          ADDR_W          = 16;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int BIT_SHORT_AGING = 0;
    localparam int BIT_DIRECTION   = 5;
    localparam int BIT_PORT_SELECT = 4;
    localparam int IDX_W           = 4;
    localparam int CMD_W           = 6;
    localparam int ENTRY_W         = 18;
    localparam int VID_W           = 12;
    localparam int PRIO_LSB        = 12;
    localparam int PRIO_W          = 3;
    localparam int PORT_ENTRY_W    = 15;
    localparam int FLAG_LSB        = 12;
    localparam int BIT_PENDING     = 0;
    localparam int NUM_PORTS       = 3;
    localparam int VLAN_ENTRIES    = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CMD_W-1:0]   RST_COMMAND    = 6'h00;
    localparam logic [ENTRY_W-1:0] RST_WRITE_DATA = 18'h00000;
    localparam logic [ENTRY_W-1:0] RST_READ_DATA  = 18'h00000;
    localparam logic [VID_W-1:0]   NULL_VID       = 12'h000;

    // ------------------------------------------------------------------
    // Aging timer
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ         = 64'd20_000_000;
    localparam longint unsigned AGE_NORMAL_S   = 64'd300;
    localparam longint unsigned AGE_TEST_MS    = 64'd50;
    localparam longint unsigned AGE_NORMAL_CYC = AGE_NORMAL_S * CLK_HZ;
    localparam longint unsigned AGE_TEST_CYC   = AGE_TEST_MS * CLK_HZ / 64'd1000;
    localparam int              AGE_W          = 33;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } access_state_t;

endpackage : vlan_table_pkg

/* File: inc/table_port_if.sv */
`timescale 1ns/10ps
interface table_port_if;
    logic        wr_en;
    logic        sel_port;
    logic [3:0]  index;
    logic [17:0] wdata;
    logic [17:0] rdata;
    logic [11:0] lookup_vid;
    logic [1:0]  lookup_port;
    logic        hit;
    logic [2:0]  member;
    logic [2:0]  untag;
    logic [14:0] port_default;

    modport ctrl (
        output wr_en, sel_port, index, wdata, lookup_vid, lookup_port,
        input  rdata, hit, member, untag, port_default
    );
    modport store (
        input  wr_en, sel_port, index, wdata, lookup_vid, lookup_port,
        output rdata, hit, member, untag, port_default
    );
endinterface : table_port_if

/* File: rtl/vlan_table_store.sv */
`timescale 1ns/10ps
module vlan_table_store (
    input  wire logic  i_ref_clk,
    input  wire logic  i_rstn,
    table_port_if.store tp
);

    logic [17:0] vlan_mem      [16];
    logic [17:0] next_vlan_mem [16];
    logic [14:0] port_mem      [3];
    logic [14:0] next_port_mem [3];

    // ------------------------------------------------------------------
    // Table update
    // ------------------------------------------------------------------
    always_comb begin
        next_vlan_mem = vlan_mem;
        next_port_mem = port_mem;
        if (tp.wr_en && !tp.sel_port) begin
            next_vlan_mem[tp.index] = tp.wdata;
        end else if (tp.wr_en && tp.sel_port && tp.index < 4'h3) begin
            next_port_mem[tp.index[1:0]] = tp.wdata[14:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            for (int i = 0; i < 16; i++) begin
                vlan_mem[i] <= vlan_table_pkg::RST_WRITE_DATA;
            end
            for (int i = 0; i < 3; i++) begin
                port_mem[i] <= 15'h0000;
            end
        end else begin
            vlan_mem <= next_vlan_mem;
            port_mem <= next_port_mem;
        end
    end

    // ------------------------------------------------------------------
    // Software read and frame lookup
    // ------------------------------------------------------------------
    always_comb begin
        tp.rdata        = 18'h00000;
        tp.hit          = 1'b0;
        tp.member       = 3'h0;
        tp.untag        = 3'h0;
        tp.port_default = 15'h0000;
        if (!tp.sel_port) begin
            tp.rdata = vlan_mem[tp.index];
        end else if (tp.index < 4'h3) begin
            tp.rdata = {3'h0, port_mem[tp.index[1:0]]};
        end
        if (tp.lookup_port < 2'h3) begin
            tp.port_default = port_mem[tp.lookup_port];
        end
        // Null VID never matches, so a cleared entry is disabled
        for (int e = 15; e >= 0; e--) begin
            if (tp.lookup_vid != vlan_table_pkg::NULL_VID &&
                vlan_mem[e][11:0] == tp.lookup_vid) begin
                tp.hit = 1'b1;
                for (int p = 0; p < 3; p++) begin
                    tp.member[p] = vlan_mem[e][vlan_table_pkg::FLAG_LSB + 2*p + 1];
                    tp.untag[p]  = vlan_mem[e][vlan_table_pkg::FLAG_LSB + 2*p];
                end
            end
        end
    end

endmodule : vlan_table_store

/* File: rtl/vlan_table_access_regs.sv */
`timescale 1ns/10ps
module vlan_table_access_regs #(
    parameter longint unsigned AGE_NORMAL_CYCLES = vlan_table_pkg::AGE_NORMAL_CYC,
    parameter longint unsigned AGE_TEST_CYCLES   = vlan_table_pkg::AGE_TEST_CYC
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic [15:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic [11:0] i_lookup_vid,
    input  wire logic [1:0]  i_lookup_port,
    input  wire logic [2:0]  i_admit_nonmember,
    output logic             o_lookup_hit,
    output logic             o_ingress_accept,
    output logic      [2:0]  o_egress_members,
    output logic             o_strip_tag,
    output logic      [11:0] o_default_vid,
    output logic      [2:0]  o_default_prio,
    output logic             o_short_aging,
    output logic             o_age_tick
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hits(input logic [15:0] addr, input logic [15:0] idx);
        hits = (addr == {idx[13:0], 2'b00});
    endfunction : hits

    table_port_if tp ();

    vlan_table_store u_store (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .tp        (tp)
    );

    vlan_table_pkg::access_state_t state;
    vlan_table_pkg::access_state_t next_state;
    logic        short_aging;
    logic        next_short_aging;
    logic [5:0]  command;
    logic [5:0]  next_command;
    logic [17:0] write_data;
    logic [17:0] next_write_data;
    logic [17:0] read_data;
    logic [17:0] next_read_data;
    logic        pending;
    logic        next_pending;
    logic [31:0] next_rdata;
    logic        cmd_wr;

    assign cmd_wr = i_wr && hits(i_addr, vlan_table_pkg::IDX_COMMAND);

    // ------------------------------------------------------------------
    // Registers and access sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_short_aging = short_aging;
        next_command     = command;
        next_write_data  = write_data;
        next_read_data   = read_data;
        next_pending     = pending;
        next_rdata       = 32'h00000000;
        tp.wr_en         = 1'b0;
        tp.sel_port      = command[vlan_table_pkg::BIT_PORT_SELECT];
        tp.index         = command[3:0];
        tp.wdata         = write_data;
        tp.lookup_vid    = i_lookup_vid;
        tp.lookup_port   = i_lookup_port;

        if (state == vlan_table_pkg::ST_EXEC) begin
            if (command[vlan_table_pkg::BIT_DIRECTION]) begin
                next_read_data = tp.rdata;
            end else begin
                tp.wr_en = 1'b1;
            end
            next_pending = 1'b0;
            next_state   = vlan_table_pkg::ST_IDLE;
        end

        if (i_wr) begin
            if (hits(i_addr, vlan_table_pkg::IDX_AGING_CTRL)) begin
                next_short_aging = i_wdata[vlan_table_pkg::BIT_SHORT_AGING];
            end else if (cmd_wr) begin
                next_command = i_wdata[5:0];
                next_pending = 1'b1;
                next_state   = vlan_table_pkg::ST_EXEC;
            end else if (hits(i_addr, vlan_table_pkg::IDX_WRITE_DATA)) begin
                next_write_data = i_wdata[17:0];
            end
        end

        if (i_rd) begin
            if (hits(i_addr, vlan_table_pkg::IDX_AGING_CTRL)) begin
                next_rdata = {31'h00000000, short_aging};
            end else if (hits(i_addr, vlan_table_pkg::IDX_COMMAND)) begin
                next_rdata = {26'h0000000, command};
            end else if (hits(i_addr, vlan_table_pkg::IDX_WRITE_DATA)) begin
                next_rdata = {14'h0000, write_data};
            end else if (hits(i_addr, vlan_table_pkg::IDX_READ_DATA)) begin
                next_rdata = {14'h0000, read_data};
            end else if (hits(i_addr, vlan_table_pkg::IDX_STATUS)) begin
                next_rdata = {31'h00000000, pending};
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state       <= vlan_table_pkg::ST_IDLE;
            short_aging <= 1'b0;
            command     <= vlan_table_pkg::RST_COMMAND;
            write_data  <= vlan_table_pkg::RST_WRITE_DATA;
            read_data   <= vlan_table_pkg::RST_READ_DATA;
            pending     <= 1'b0;
            o_rdata     <= 32'h00000000;
        end else begin
            state       <= next_state;
            short_aging <= next_short_aging;
            command     <= next_command;
            write_data  <= next_write_data;
            read_data   <= next_read_data;
            pending     <= next_pending;
            o_rdata     <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Frame lookup results
    // ------------------------------------------------------------------
    logic        next_hit;
    logic        next_accept;
    logic [2:0]  next_egress;
    logic        next_strip;
    logic        port_ok;

    always_comb begin
        port_ok     = (i_lookup_port < 2'h3);
        next_hit    = tp.hit;
        next_egress = tp.member;
        next_accept = 1'b0;
        next_strip  = 1'b0;
        if (port_ok) begin
            next_accept = tp.member[i_lookup_port] ||
                          i_admit_nonmember[i_lookup_port];
            next_strip  = tp.untag[i_lookup_port];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_lookup_hit     <= 1'b0;
            o_ingress_accept <= 1'b0;
            o_egress_members <= 3'h0;
            o_strip_tag      <= 1'b0;
            o_default_vid    <= 12'h000;
            o_default_prio   <= 3'h0;
        end else begin
            o_lookup_hit     <= next_hit;
            o_ingress_accept <= next_accept;
            o_egress_members <= next_egress;
            o_strip_tag      <= next_strip;
            o_default_vid    <= tp.port_default[11:0];
            o_default_prio   <= tp.port_default[14:12];
        end
    end

    // ------------------------------------------------------------------
    // Aging timer
    // ------------------------------------------------------------------
    logic [32:0] age_count;
    logic [32:0] next_age_count;
    logic [32:0] age_limit;
    logic        next_age_tick;

    always_comb begin
        age_limit      = short_aging ? AGE_TEST_CYCLES[32:0]
                                     : AGE_NORMAL_CYCLES[32:0];
        next_age_count = age_count + 33'h000000001;
        next_age_tick  = 1'b0;
        if (age_count >= age_limit - 33'h000000001) begin
            next_age_count = 33'h000000000;
            next_age_tick  = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            age_count     <= 33'h000000000;
            o_age_tick    <= 1'b0;
            o_short_aging <= 1'b0;
        end else begin
            age_count     <= next_age_count;
            o_age_tick    <= next_age_tick;
            o_short_aging <= short_aging;
        end
    end

endmodule : vlan_table_access_regs

/* File: dv/vlan_table_access_regs_checker.sv */
`timescale 1ns/10ps
module vlan_table_access_regs_checker #(
    parameter longint unsigned AGE_NORMAL_CYCLES = 20,
    parameter longint unsigned AGE_TEST_CYCLES   = 5
) (
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    input wire logic [15:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  i_lookup_port,
    input wire logic [2:0]  i_admit_nonmember,
    input wire logic        o_lookup_hit,
    input wire logic        o_ingress_accept,
    input wire logic [2:0]  o_egress_members,
    input wire logic        o_short_aging,
    input wire logic        o_age_tick
);
    localparam logic [15:0] A_AGE = 16'(vlan_table_pkg::IDX_AGING_CTRL << 2);
    localparam logic [15:0] A_CMD = 16'(vlan_table_pkg::IDX_COMMAND << 2);
    localparam logic [15:0] A_WD  = 16'(vlan_table_pkg::IDX_WRITE_DATA << 2);
    localparam logic [15:0] A_ST  = 16'(vlan_table_pkg::IDX_STATUS << 2);
    logic [63:0] gap;
    logic        seen;
    logic        chg;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    // ------------------------------------------------------------------
    // Cycles since last tick, mode change seen in between
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            gap  <= 64'h0;
            seen <= 1'b0;
            chg  <= 1'b0;
        end else begin
            gap  <= o_age_tick ? 64'h0 : gap + 64'h1;
            seen <= seen | o_age_tick;
            chg  <= $changed(o_short_aging) | (chg & ~o_age_tick);
        end
    end

    sequence s_wr(a);
        i_wr && i_addr == a;
    endsequence
    sequence s_rd(a);
        i_rd && i_addr == a;
    endsequence
    property p_rb(a, m);
        s_wr(a) ##1 s_rd(a) |=> o_rdata == ($past(i_wdata, 2) & m);
    endproperty
    property p_gap;
        o_age_tick && seen && !chg && !$changed(o_short_aging)
            |-> gap == (o_short_aging ? AGE_TEST_CYCLES : AGE_NORMAL_CYCLES) - 64'h1;
    endproperty

    AST_RSVD_ZERO: assert property ($past(i_rd) |-> o_rdata[31:18] == 14'h0)
        else $error("reserved read bits not zero");
    AST_AGE_RB: assert property (p_rb(A_AGE, 32'h1))
        else $error("aging control readback wrong");
    AST_CMD_RB: assert property (p_rb(A_CMD, 32'h3F))
        else $error("command readback wrong");
    AST_WDAT_RB: assert property (p_rb(A_WD, 32'h3FFFF))
        else $error("write payload readback wrong");
    AST_AGE_OUT: assert property (s_wr(A_AGE) ##1 !(i_wr && i_addr == A_AGE)
        |=> o_short_aging == |($past(i_wdata, 2) & 32'h1))
        else $error("short aging output wrong");
    AST_TICK_GAP: assert property (p_gap)
        else $error("aging tick period wrong");
    AST_TICK_PULSE: assert property (o_age_tick |=> !o_age_tick)
        else $error("aging tick longer than one cycle");
    AST_PEND_SET: assert property (s_wr(A_CMD) ##1 s_rd(A_ST) |=> o_rdata == 32'h1)
        else $error("pending not set after command");
    AST_PEND_CLR: assert property (s_wr(A_CMD) ##1 !(i_wr && i_addr == A_CMD)
        ##1 s_rd(A_ST) |=> o_rdata == 32'h0)
        else $error("pending not cleared");
    AST_MISS_EMPTY: assert property (!o_lookup_hit |-> o_egress_members == 3'h0)
        else $error("members on a miss");
    AST_ACCEPT: assert property (o_lookup_hit && $past(i_lookup_port) != 2'h3 |->
        o_ingress_accept == |((o_egress_members | $past(i_admit_nonmember))
            & (3'h1 << $past(i_lookup_port))))
        else $error("ingress accept wrong");
endmodule : vlan_table_access_regs_checker

bind vlan_table_access_regs vlan_table_access_regs_checker #(
    .AGE_NORMAL_CYCLES(AGE_NORMAL_CYCLES),
    .AGE_TEST_CYCLES  (AGE_TEST_CYCLES)
) u_vlan_table_access_regs_checker (
    .i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_lookup_port,
    .i_admit_nonmember, .o_lookup_hit, .o_ingress_accept, .o_egress_members,
    .o_short_aging, .o_age_tick
);

/* File: dv/vlan_table_access_regs_tb_top.sv */
`timescale 1ns/10ps
module vlan_table_access_regs_tb_top;
    localparam longint unsigned NCYC = 20;
    localparam longint unsigned TCYC = 5;
    localparam logic [15:0] A_AGE = 16'(vlan_table_pkg::IDX_AGING_CTRL << 2);
    localparam logic [15:0] A_CMD = 16'(vlan_table_pkg::IDX_COMMAND << 2);
    localparam logic [15:0] A_WD  = 16'(vlan_table_pkg::IDX_WRITE_DATA << 2);
    localparam logic [15:0] A_RD  = 16'(vlan_table_pkg::IDX_READ_DATA << 2);
    localparam logic [15:0] A_ST  = 16'(vlan_table_pkg::IDX_STATUS << 2);
    logic        i_ref_clk, i_rstn, i_wr, i_rd, o_lookup_hit, o_ingress_accept;
    logic        o_strip_tag, o_short_aging, o_age_tick;
    logic [15:0] i_addr, lfsr_q;
    logic [31:0] i_wdata, o_rdata, r;
    logic [11:0] i_lookup_vid, o_default_vid, vid;
    logic [1:0]  i_lookup_port;
    logic [2:0]  i_admit_nonmember, o_egress_members, o_default_prio;
    logic [17:0] vtab [16];
    logic [14:0] ptab [3];
    logic [15:0] regs [6] = '{A_AGE, A_CMD, A_WD, A_RD, A_ST, 16'h6034};
    int          n_mismatch, samples_checked, n;

    vlan_table_access_regs #(.AGE_NORMAL_CYCLES(NCYC), .AGE_TEST_CYCLES(TCYC))
    u_vlan_table_access_regs (
        .i_ref_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_lookup_vid,
        .i_lookup_port, .i_admit_nonmember, .o_lookup_hit, .o_ingress_accept,
        .o_egress_members, .o_strip_tag, .o_default_vid, .o_default_prio,
        .o_short_aging, .o_age_tick
    );

    // ------------------------------------------------------------------
    // Bus, model and compare tasks
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        logic [15:0] a;
        a = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        lfsr_q = {a[14:0], a[15] ^ a[13] ^ a[12] ^ a[10]};
        return {a, lfsr_q};
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic cyc(input logic w, input logic rq, input logic [15:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr    <= w;
        i_rd    <= rq;
        i_addr  <= a;
        i_wdata <= d;
    endtask : cyc
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        cyc(1'b0, 1'b1, a, 32'h0);
        cyc(1'b0, 1'b0, a, 32'h0);
        #1;
        chk(o_rdata, exp);
    endtask : rd
    task automatic tab_wr(input logic p, input logic [3:0] idx, input logic [31:0] d);
        wr(A_WD, d);
        wr(A_CMD, {26'h0, 1'b0, p, idx});
        rd(A_ST, 32'h1);
        rd(A_ST, 32'h0);
        if (p) ptab[idx] = d[14:0];
        else vtab[idx] = d[17:0];
    endtask : tab_wr
    task automatic tab_rd(input logic p, input logic [3:0] idx);
        wr(A_CMD, {26'h0, 1'b1, p, idx});
        cyc(1'b0, 1'b0, A_ST, 32'h0);
        rd(A_ST, 32'h0);
        rd(A_RD, p ? 32'(ptab[idx]) : 32'(vtab[idx]));
    endtask : tab_rd
    task automatic look(input logic [11:0] v, input logic [1:0] p, input logic [2:0] adm);
        logic [17:0] e;
        logic        hit;
        e = 18'h0;
        hit = 1'b0;
        for (int k = 15; k >= 0; k--) if (vtab[k][11:0] == v && v != 12'h0) begin
            hit = 1'b1;
            e = vtab[k];
        end
        @(posedge i_ref_clk);
        i_lookup_vid      <= v;
        i_lookup_port     <= p;
        i_admit_nonmember <= adm;
        @(posedge i_ref_clk);
        #1;
        chk(o_lookup_hit, hit);
        chk(o_egress_members, {e[17], e[15], e[13]});
        chk(o_ingress_accept, e[13 + 2 * p] | adm[p]);
        chk(o_strip_tag, e[12 + 2 * p]);
        chk({o_default_prio, o_default_vid}, ptab[p]);
    endtask : look
    task automatic tick_gap(output int c);
        c = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            c++;
        end while (o_age_tick !== 1'b1 && c < 100);
    endtask : tick_gap

    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        n_mismatch++;
        end_sim();
    end
    initial begin
        {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
        {i_lookup_vid, i_lookup_port, i_admit_nonmember} = '0;
        n_mismatch = 0;
        samples_checked = 0;
        lfsr_q = 16'h2F18;
        foreach (vtab[k]) vtab[k] = 18'h0;
        foreach (ptab[k]) ptab[k] = 15'h0;
        repeat (20) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        foreach (regs[k]) rd(regs[k], 32'h0);
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            wr(A_AGE, r);
            rd(A_AGE, r & 32'h1);
            chk(o_short_aging, r[0]);
            wr(A_WD, r);
            rd(A_WD, r & 32'h3FFFF);
            wr(A_CMD, {r[31:6], 2'b10, r[3:0]});
            rd(A_CMD, {26'h0, 2'b10, r[3:0]});
        end
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            vid = (r[11:0] == 12'h0 || r[11:0] == 12'h3FF) ? 12'h7 : r[11:0];
            if (k == 9) vid = vtab[3][11:0];
            if (k == 15) vid = 12'h0;
            tab_wr(1'b0, 4'(k), {r[31:12], vid});
        end
        for (int k = 0; k < 3; k++) tab_wr(1'b1, 4'(k), rnd());
        wr(A_CMD, 32'h23);
        wr(A_CMD, 32'h31);
        rd(A_ST, 32'h1);
        rd(A_RD, 32'(ptab[1]));
        for (int k = 0; k < 16; k++) tab_rd(1'b0, 4'(k));
        for (int k = 0; k < 3; k++) tab_rd(1'b1, 4'(k));
        for (int k = 0; k < 48; k++) begin
            r = rnd();
            look(r[4] ? vtab[r[3:0]][11:0] : r[27:16], (r[6:5] == 2'h3) ? 2'h2 : r[6:5], r[10:8]);
        end
        for (int m = 1; m >= 0; m--) begin
            wr(A_AGE, 32'(m));
            rd(A_AGE, 32'(m));
            tick_gap(n);
            tick_gap(n);
            chk(n, m ? 32'(TCYC) : 32'(NCYC));
        end
        end_sim();
    end
endmodule : vlan_table_access_regs_tb_top
